// ---- hw/sac_pkg.sv ----
// constants and register map of the slope converter control block
// How it works
// - a 4-bit ramp current code of zero turns every source off and each step adds 2.25 uA up to 33.75 uA.
// - while the halt/discharge bit is set the ramp sources stay off, and they start only once it clears.
// - two control registers at indices 1Fh and 9Fh are both readable and writable.
// - bits 7:4 of the primary register select the analog multiplexer channel.
// - bit 3 of the primary register is not implemented and reads as zero.
// - bit 2 of the primary register routes the multiplexer output onto analog pin zero over its direction.
// - bit 1 of the primary register stops the conversion timer and discharges the ramp capacitor.
// - bit 0 of the primary register enables zeroing on the two level-shifted inputs.
// - bits 7:4 of the secondary register hold the ramp current code applied to the source.
// - each 2-bit group field makes 00 all analog, 01 pin 3 digital, 10 pins 2-3 digital, 11 all digital.
// - an N-bit conversion takes 2 to the N clock periods of timer counting.
// - clearing the halt/discharge bit starts the timer counting and the ramp charging.
// - the conversion timer is a 16-bit up counter that steps once per clock while running.
// - the four channel bits pick one of sixteen inputs, two codes of which are reserved.
package sac_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned DISCHARGE_MIN_US = 200;
   // least time; whole microseconds times MHz is already exact
   localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_MIN_US * CLK_MHZ;

   localparam int unsigned ADDR_W = 12;
   localparam logic [7:0] PRIMARY_IDX = 8'h1F;
   localparam logic [7:0] SECONDARY_IDX = 8'h9F;
   localparam logic [11:0] PRIMARY_ADDR = {2'h0, PRIMARY_IDX, 2'h0};
   localparam logic [11:0] SECONDARY_ADDR = {2'h0, SECONDARY_IDX, 2'h0};
   localparam logic [11:0] TIMER_ADDR = 12'h300;
   localparam logic [11:0] RESOLUTION_ADDR = 12'h304;
   localparam logic [11:0] STATUS_ADDR = 12'h308;

   localparam int unsigned CHSEL_LSB = 4;
   localparam int unsigned MUXOE_BIT = 2;
   localparam int unsigned HALT_BIT = 1;
   localparam int unsigned ZERO_BIT = 0;
   localparam int unsigned CURRENT_LSB = 4;
   localparam int unsigned GRPB_LSB = 2;
   localparam int unsigned GRPA_LSB = 0;

   localparam int unsigned ST_RUNNING = 0;
   localparam int unsigned ST_DISCHARGED = 1;
   localparam int unsigned ST_CONV_DONE = 2;
   localparam int unsigned ST_OVERFLOW = 3;
   localparam int unsigned ST_RESERVED_CH = 4;

   localparam logic [7:0] PRIMARY_RST = 8'h02;
   localparam logic [7:0] PRIMARY_WMASK = 8'hF7;
   localparam logic [7:0] SECONDARY_RST = 8'h00;
   localparam logic [4:0] RESOLUTION_RST = 5'h10;
   localparam logic [4:0] RESOLUTION_MAX = 5'h10;
   localparam logic [15:0] TIMER_RST = 16'h0000;

   // one current step in units of 10 nA (2.25 uA)
   localparam logic [11:0] CURRENT_STEP_10NA = 12'h0E1;
   localparam logic [3:0] CHAN_RESERVED_FIRST = 4'hE;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/sac_timer.sv ----
// conversion timer: 16-bit up counter with run-time tally
`timescale 1ns/1ps
module sac_timer
   import sac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_load,
   input wire logic [15:0] i_load_value,
   output logic [15:0] o_count,
   output logic [16:0] o_elapsed,
   output logic o_overflow
);
   wire [15:0] next_count = o_count + 16'h0001;
   // tally saturates so it never wraps back onto a match value
   wire tally_full = o_elapsed[16];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_count <= TIMER_RST;
         o_overflow <= 1'b0;
      end else begin
         o_overflow <= i_run && !i_load && (o_count == 16'hFFFF);
         if (i_load) begin
            o_count <= i_load_value;
         end else if (i_run) begin
            o_count <= next_count;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         o_elapsed <= 17'h00000;
      end else if (!tally_full) begin
         o_elapsed <= o_elapsed + 17'h00001;
      end
   end
endmodule

// ---- hw/sac_ctrl.sv ----
// slope converter control registers with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int unsigned DISCHARGE_COUNT = DISCHARGE_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   // write address channel
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [11:0] i_awaddr,
   input wire logic [2:0] i_awprot,
   // write data channel
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // write response channel
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // read address channel
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [11:0] i_araddr,
   input wire logic [2:0] i_arprot,
   // read data channel
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // converter controls
   output logic [3:0] o_channel_select,
   output logic o_channel_reserved,
   output logic o_mux_to_pin_enable,
   output logic o_conversion_halt_discharge,
   output logic o_timer_stop,
   output logic o_capacitor_discharge,
   output logic o_zeroing_select,
   output logic [3:0] o_ramp_current_code,
   output logic o_ramp_current_on,
   output logic [11:0] o_ramp_current_10na,
   output logic [3:0] o_first_pin_group_digital,
   output logic [3:0] o_second_pin_group_digital,
   output logic [15:0] o_conversion_timer,
   output logic o_conversion_done
);
   logic [7:0] primary;
   logic [7:0] secondary;
   logic [4:0] resolution;
   logic conv_done_flag;
   logic overflow_flag;
   logic [15:0] discharge_cnt;

   // write side holding registers
   logic aw_held;
   logic [11:0] aw_addr_q;
   logic w_held;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   wire aw_hs = i_awvalid && o_awready;
   wire w_hs = i_wvalid && o_wready;
   wire aw_have = aw_held || aw_hs;
   wire w_have = w_held || w_hs;
   // write commits on the edge where both halves are present
   wire do_write = aw_have && w_have && !o_bvalid;
   wire [11:0] wr_addr = aw_held ? aw_addr_q : i_awaddr;
   wire [31:0] wr_data = w_held ? w_data_q : i_wdata;
   wire [3:0] wr_strb = w_held ? w_strb_q : i_wstrb;

   wire wr_primary = do_write && (wr_addr == PRIMARY_ADDR);
   wire wr_secondary = do_write && (wr_addr == SECONDARY_ADDR);
   wire wr_timer = do_write && (wr_addr == TIMER_ADDR);
   wire wr_resolution = do_write && (wr_addr == RESOLUTION_ADDR);
   wire wr_status = do_write && (wr_addr == STATUS_ADDR);
   wire wr_mapped = wr_primary || wr_secondary || wr_timer ||
      wr_resolution || wr_status;

   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aw_held <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (aw_hs) begin
         aw_held <= 1'b1;
         aw_addr_q <= i_awaddr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         w_held <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (w_hs) begin
         w_held <= 1'b1;
         w_data_q <= i_wdata;
         w_strb_q <= i_wstrb;
      end
   end

   // response holds until the master takes it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // control registers
   wire [7:0] next_primary = wr_data[7:0] & PRIMARY_WMASK;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         primary <= PRIMARY_RST;
         secondary <= SECONDARY_RST;
      end else begin
         if (wr_primary && wr_strb[0]) begin
            primary <= next_primary;
         end
         if (wr_secondary && wr_strb[0]) begin
            secondary <= wr_data[7:0];
         end
      end
   end

   wire [4:0] res_in = wr_data[4:0];
   // out-of-range widths are ignored rather than clamped
   wire res_ok = (res_in != 5'h00) && (res_in <= RESOLUTION_MAX);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         resolution <= RESOLUTION_RST;
      end else if (wr_resolution && wr_strb[0] && res_ok) begin
         resolution <= res_in;
      end
   end

   // field decode
   wire halt = primary[HALT_BIT];
   wire [3:0] current_code = secondary[CURRENT_LSB +: 4];
   wire [1:0] group_a_cfg = secondary[GRPA_LSB +: 2];
   wire [1:0] group_b_cfg = secondary[GRPB_LSB +: 2];

   assign o_channel_select = primary[CHSEL_LSB +: 4];
   assign o_channel_reserved = o_channel_select >= CHAN_RESERVED_FIRST;
   assign o_mux_to_pin_enable = primary[MUXOE_BIT];
   assign o_conversion_halt_discharge = halt;
   assign o_timer_stop = halt;
   assign o_capacitor_discharge = halt;
   assign o_zeroing_select = primary[ZERO_BIT];
   assign o_ramp_current_code = current_code;

   // sources are held off by the halt bit whatever the code says
   assign o_ramp_current_on = !halt && (current_code != 4'h0);
   wire [11:0] current_10na = 12'(current_code) * CURRENT_STEP_10NA;
   assign o_ramp_current_10na = halt ? 12'h000 : current_10na;

   // pin i turns digital once the field reaches its threshold
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         localparam logic [1:0] THRESH = (gi < 2) ? 2'h3 : 2'(4 - gi);
         assign o_first_pin_group_digital[gi] = group_a_cfg >= THRESH;
         assign o_second_pin_group_digital[gi] = group_b_cfg >= THRESH;
      end
   endgenerate

   // conversion timer
   wire timer_run = !halt;
   // lanes merge with the running count so a half write keeps the rest
   wire [15:0] timer_load_value = {
      wr_strb[1] ? wr_data[15:8] : o_conversion_timer[15:8],
      wr_strb[0] ? wr_data[7:0] : o_conversion_timer[7:0]};
   wire timer_load = wr_timer && (wr_strb[1:0] != 2'h0);
   wire [16:0] elapsed;
   wire timer_overflow;

   sac_timer u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_run(timer_run),
      .i_load(timer_load),
      .i_load_value(timer_load_value),
      .o_count(o_conversion_timer),
      .o_elapsed(elapsed),
      .o_overflow(timer_overflow)
   );

   // conversion is complete after 2^N counted cycles
   wire [16:0] target = 17'h00001 << resolution;
   wire conv_match = timer_run && (elapsed == target);
   // the tally parks on the target at full width, so only the first
   // match of a run may set the flag; a clear then sticks
   logic hit_seen;
   wire conv_hit = conv_match && !hit_seen;

   always_ff @(posedge i_clk) begin
      if (i_rst || !timer_run) begin
         hit_seen <= 1'b0;
      end else if (conv_match) begin
         hit_seen <= 1'b1;
      end
   end

   // discharge time tally; software owns the 200 us hold, we only report it
   // saturates at the limit so the flag stays up however long the hold
   wire discharge_ok = discharge_cnt >= 16'(DISCHARGE_COUNT);

   always_ff @(posedge i_clk) begin
      if (i_rst || !halt) begin
         discharge_cnt <= 16'h0000;
      end else if (!discharge_ok) begin
         discharge_cnt <= discharge_cnt + 16'h0001;
      end
   end

   // sticky flags: a set in the clearing cycle wins
   wire clr_done = wr_status && wr_strb[0] && wr_data[ST_CONV_DONE];
   wire clr_ovf = wr_status && wr_strb[0] && wr_data[ST_OVERFLOW];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         conv_done_flag <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         if (conv_hit) begin
            conv_done_flag <= 1'b1;
         end else if (clr_done) begin
            conv_done_flag <= 1'b0;
         end
         if (timer_overflow) begin
            overflow_flag <= 1'b1;
         end else if (clr_ovf) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   assign o_conversion_done = conv_done_flag;

   // read side
   wire [31:0] status_word;
   assign status_word[ST_RUNNING] = timer_run;
   assign status_word[ST_DISCHARGED] = discharge_ok;
   assign status_word[ST_CONV_DONE] = conv_done_flag;
   assign status_word[ST_OVERFLOW] = overflow_flag;
   assign status_word[ST_RESERVED_CH] = o_channel_reserved;
   assign status_word[31:5] = 27'h0000000;

   wire rd_primary = i_araddr == PRIMARY_ADDR;
   wire rd_secondary = i_araddr == SECONDARY_ADDR;
   wire rd_timer = i_araddr == TIMER_ADDR;
   wire rd_resolution = i_araddr == RESOLUTION_ADDR;
   wire rd_status = i_araddr == STATUS_ADDR;
   wire rd_mapped = rd_primary || rd_secondary || rd_timer ||
      rd_resolution || rd_status;

   // unmapped reads answer zero with an error response
   wire [31:0] rd_word =
      rd_primary ? {24'h000000, primary} :
      rd_secondary ? {24'h000000, secondary} :
      rd_timer ? {16'h0000, o_conversion_timer} :
      rd_resolution ? {27'h0000000, resolution} :
      rd_status ? status_word : 32'h00000000;

   // one read in flight; the next address waits until the data is taken
   assign o_arready = !o_rvalid;
   wire ar_hs = i_arvalid && o_arready;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // protection bits carry no meaning for this block
   wire unused_prot = ^{i_awprot, i_arprot, wr_strb[3:2]};
endmodule

// ---- bench/sac_ctrl_checker.sv ----
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sac_ctrl_checker
   import sac_pkg::*;
#(parameter int unsigned DISCHARGE_COUNT = DISCHARGE_CYCLES)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [11:0] i_awaddr,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic o_bvalid,
   input wire logic [3:0] o_channel_select,
   input wire logic o_channel_reserved,
   input wire logic o_mux_to_pin_enable,
   input wire logic o_conversion_halt_discharge,
   input wire logic o_timer_stop,
   input wire logic o_capacitor_discharge,
   input wire logic o_zeroing_select,
   input wire logic [3:0] o_ramp_current_code,
   input wire logic o_ramp_current_on,
   input wire logic [11:0] o_ramp_current_10na,
   input wire logic [3:0] o_first_pin_group_digital,
   input wire logic [15:0] o_conversion_timer
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic h = o_conversion_halt_discharge;
   wire logic [7:0] wd = i_wdata[7:0];
   wire logic [3:0] wc = i_wdata[7:4];
   // expected pin group decode, worked out from the written field
   wire logic [3:0] gx = {|wd[1:0], wd[1], &wd[1:0], &wd[1:0]};
   wire logic hs = i_awvalid && o_awready && i_wvalid && o_wready;
   wire logic wr = hs && i_wstrb[0];
   cur_value_a: assert property (
      o_ramp_current_10na == (h ? 12'h0 : o_ramp_current_code * 12'h0E1))
      else $error("ramp current value wrong");
   cur_gate_a: assert property (
      o_ramp_current_on == (!h && o_ramp_current_code != 4'h0))
      else $error("ramp current gate wrong");
   halt_fan_a: assert property (
      o_timer_stop == h && o_capacitor_discharge == h)
      else $error("halt fan-out wrong");
   chan_rsvd_a: assert property (
      o_channel_reserved == (o_channel_select >= 4'hE))
      else $error("reserved channel flag wrong");
   // a completed write may reload the timer, so that edge is skipped
   timer_step_a: assert property (
      !$past(h) && !$rose(o_bvalid) |->
      o_conversion_timer == $past(o_conversion_timer) + 16'h1)
      else $error("timer did not step");
   prim_write_a: assert property (
      wr && i_awaddr == PRIMARY_ADDR |=> {o_channel_select, 1'b0,
      o_mux_to_pin_enable, h, o_zeroing_select} == ($past(wd) & 8'hF7))
      else $error("primary write not applied");
   sec_write_a: assert property (
      wr && i_awaddr == SECONDARY_ADDR |=> o_ramp_current_code ==
      $past(wc) && o_first_pin_group_digital == $past(gx))
      else $error("secondary write not applied");
   wr_answer_a: assert property (
      hs |=> o_bvalid) else $error("write not answered");
   cover property (wr && i_awaddr == SECONDARY_ADDR);
   cover property ($fell(h));
   cover property (o_ramp_current_code == 4'hF && !h);
endmodule
bind sac_ctrl sac_ctrl_checker #(.DISCHARGE_COUNT(DISCHARGE_COUNT))
   sac_ctrl_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
   .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
   .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
   .o_channel_select(o_channel_select),
   .o_channel_reserved(o_channel_reserved),
   .o_mux_to_pin_enable(o_mux_to_pin_enable),
   .o_conversion_halt_discharge(o_conversion_halt_discharge),
   .o_timer_stop(o_timer_stop),
   .o_capacitor_discharge(o_capacitor_discharge),
   .o_zeroing_select(o_zeroing_select),
   .o_ramp_current_code(o_ramp_current_code),
   .o_ramp_current_on(o_ramp_current_on),
   .o_ramp_current_10na(o_ramp_current_10na),
   .o_first_pin_group_digital(o_first_pin_group_digital),
   .o_conversion_timer(o_conversion_timer));

// ---- bench/sac_ramp_model.sv ----
// ramp capacitor model charged by the block's current source
`timescale 1ns/1ps
module sac_ramp_model (
   input wire logic i_clk,
   input wire logic i_discharge,
   input wire logic [11:0] i_current_10na,
   output logic [31:0] o_level
);
   // charge in 10 nA cycles; capacitance left out as it only scales
   always_ff @(posedge i_clk) begin
      if (i_discharge) begin
         o_level <= 32'h0;
      end else begin
         o_level <= o_level + 32'(i_current_10na);
      end
   end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top
   import sac_pkg::*;
;
   logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_timer_stop;
   logic o_channel_reserved, o_mux_to_pin_enable, o_zeroing_select;
   logic o_conversion_halt_discharge, o_capacitor_discharge;
   logic o_ramp_current_on, o_conversion_done;
   logic [11:0] i_awaddr, i_araddr, o_ramp_current_10na;
   logic [31:0] i_wdata, o_rdata, lvl, t0, rd;
   logic [3:0] i_wstrb, o_channel_select, o_ramp_current_code;
   logic [3:0] o_first_pin_group_digital, o_second_pin_group_digital;
   logic [2:0] i_awprot, i_arprot;
   logic [1:0] o_bresp, o_rresp, rs;
   logic [15:0] o_conversion_timer;
   logic [3:0] gmap [4] = '{4'h0, 4'h8, 4'hC, 4'hF};
   int n_mismatch = 0;
   int num_checks = 0;
   wire logic [7:0] prim = {o_channel_select, o_channel_reserved,
      o_mux_to_pin_enable, o_conversion_halt_discharge, o_zeroing_select};
   wire logic [7:0] grp = {o_first_pin_group_digital,
      o_second_pin_group_digital};
   sac_ctrl #(.DISCHARGE_COUNT(20)) sac_ctrl_inst (.i_clk(i_clk),
      .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_awaddr(i_awaddr), .i_awprot(i_awprot), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
      .i_arprot(i_arprot), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_channel_select(o_channel_select),
      .o_channel_reserved(o_channel_reserved),
      .o_mux_to_pin_enable(o_mux_to_pin_enable),
      .o_conversion_halt_discharge(o_conversion_halt_discharge),
      .o_timer_stop(o_timer_stop),
      .o_capacitor_discharge(o_capacitor_discharge),
      .o_zeroing_select(o_zeroing_select),
      .o_ramp_current_code(o_ramp_current_code),
      .o_ramp_current_on(o_ramp_current_on),
      .o_ramp_current_10na(o_ramp_current_10na),
      .o_first_pin_group_digital(o_first_pin_group_digital),
      .o_second_pin_group_digital(o_second_pin_group_digital),
      .o_conversion_timer(o_conversion_timer),
      .o_conversion_done(o_conversion_done));
   sac_ramp_model sac_ramp_model_inst (.i_clk(i_clk),
      .i_discharge(o_capacitor_discharge),
      .i_current_10na(o_ramp_current_10na), .o_level(lvl));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one register access; handshakes judged at the negedge before the edge
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      @(posedge i_clk);
      {i_awvalid, i_wvalid, i_bready} <= {3{w}};
      {i_arvalid, i_rready} <= {2{!w}};
      {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
      // no cycle budget here; only the watchdog ends a stuck wait
      forever begin
         @(negedge i_clk);
         ha = (i_awvalid && o_awready) || (i_arvalid && o_arready);
         hw = i_wvalid && o_wready;
         hb = (i_bready && o_bvalid) || (i_rready && o_rvalid);
         {rs, rd} = w ? {o_bresp, 32'h0} : {o_rresp, o_rdata};
         @(posedge i_clk);
         if (ha) {i_awvalid, i_arvalid} <= 2'h0;
         if (hw) i_wvalid <= 1'b0;
         if (hb) begin
            {i_bready, i_rready} <= 2'h0;
            break;
         end
      end
      chk(32'(rs), 32'(er));
      if (!w) chk(rd, d);
   endtask
   task automatic s_primary();
      @(negedge i_clk);
      chk(32'(prim), 32'h02);
      xfer(0, PRIMARY_ADDR, 32'h2, RESP_OKAY);
      xfer(1, PRIMARY_ADDR, 32'hFF, RESP_OKAY);
      xfer(0, PRIMARY_ADDR, 32'hF7, RESP_OKAY);
      @(negedge i_clk);
      chk(32'(prim), 32'hFF);
      // discharge hold before the halt bit is released
      repeat (20) @(negedge i_clk);
      xfer(1, PRIMARY_ADDR, 32'hD4, RESP_OKAY);
      @(negedge i_clk);
      chk(32'(prim), 32'hD4);
      @(posedge i_clk);
      i_wstrb <= 4'h0;
      xfer(1, PRIMARY_ADDR, 32'h0, RESP_OKAY);
      i_wstrb <= 4'hF;
      xfer(0, PRIMARY_ADDR, 32'hD4, RESP_OKAY);
      xfer(1, 12'h010, 32'h1, RESP_SLVERR);
      xfer(0, 12'h010, 32'h0, RESP_SLVERR);
   endtask
   task automatic s_current();
      int v;
      for (int c = 0; c < 16; c++) begin
         v = c * 16 + c % 4 * 5;
         xfer(1, SECONDARY_ADDR, 32'(v), RESP_OKAY);
         xfer(0, SECONDARY_ADDR, 32'(v), RESP_OKAY);
         @(negedge i_clk);
         t0 = lvl;
         @(negedge i_clk);
         chk(lvl - t0, 32'(c * 225));
         chk(32'(grp), 32'({gmap[c % 4], gmap[c % 4]}));
      end
      xfer(1, PRIMARY_ADDR, 32'h2, RESP_OKAY);
      @(negedge i_clk);
      chk(32'(o_ramp_current_on), 32'h0);
      chk(lvl, 32'h0);
   endtask
   task automatic s_timer();
      xfer(1, RESOLUTION_ADDR, 32'h4, RESP_OKAY);
      xfer(1, STATUS_ADDR, 32'hC, RESP_OKAY);
      xfer(0, STATUS_ADDR, 32'h0, RESP_OKAY);
      repeat (20) @(negedge i_clk);
      xfer(0, STATUS_ADDR, 32'h2, RESP_OKAY);
      xfer(1, TIMER_ADDR, 32'h1234, RESP_OKAY);
      xfer(0, TIMER_ADDR, 32'h1234, RESP_OKAY);
      xfer(1, PRIMARY_ADDR, 32'h0, RESP_OKAY);
      @(negedge i_clk);
      t0 = 32'(o_conversion_timer);
      chk(t0, 32'h1235);
      repeat (8) @(negedge i_clk);
      chk(32'(o_conversion_timer - t0[15:0]), 32'h8);
      chk(32'(o_conversion_done), 32'h0);
      repeat (10) @(negedge i_clk);
      chk(32'(o_conversion_done), 32'h1);
      xfer(1, STATUS_ADDR, 32'h4, RESP_OKAY);
      xfer(0, STATUS_ADDR, 32'h1, RESP_OKAY);
      chk(32'(o_conversion_done), 32'h0);
   endtask
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      i_rst = 1'b1;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
      {i_awaddr, i_araddr, i_wdata} = 56'h0;
      {i_awprot, i_arprot} = 6'h0;
      i_wstrb = 4'hF;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      s_primary();
      s_current();
      s_timer();
      complete_run();
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      complete_run();
   end
endmodule
